/* hw/bcx_pkg.sv */
// constants, opcodes and states for the branch, call, clear and compare executor
package bcx_pkg;
  localparam logic [7:0] OP_BRANCH_ZERO = 8'hE0;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [6:0] OP_CLEAR_FILE = 7'h35;
  localparam logic [15:0] OP_WATCHDOG_RESTART = 16'h0004;
  localparam logic [4:0] OP_COMPARE = 5'h0C;
  localparam logic [3:0] OP_MOVE_FF = 4'hC;
  localparam logic [7:0] OP_GOTO = 8'hEF;
  localparam logic [7:0] OP_LOAD_INDEX = 8'hEE;
  localparam logic [1:0] CMP_LESS = 2'h0;
  localparam logic [1:0] CMP_EQUAL = 2'h1;
  localparam logic [1:0] CMP_GREATER = 2'h2;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] HIGH_ACCESS_BANK = 4'hF;
  localparam logic [3:0] LOW_ACCESS_BANK = 4'h0;
  localparam int ZERO_BIT = 2;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] CALL_RETURN_STEP = 21'h000004;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  typedef enum logic [2:0] {S_DECODE, S_CALL2, S_CMP, S_SKIP2, S_DEAD} bcx_state_t;
endpackage

/* hw/bcx_file_ram.sv */
// file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bcx_file_ram #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [ADDR_W-1:0] raddr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

/* hw/bcx_exec.sv */
// executor for branch on zero, call, clear file, watchdog restart and compare-skip
// Function
// - two-word call pushes PC+4 to stack top, loads 20-bit target into PC.
// - call with save bit copies accumulator, flags, bank select to shadows.
// - clear file writes zero to the file, sets zero flag, one cycle.
// - watchdog restart zeroes count and postscaler, sets both flags to one.
// - compare-skip-less skips next word when file below accumulator, unsigned.
// - compare-skip-greater skips when file above; two-word victim costs three cycles.
// - access bit 0 with extended set: files up to 95 are indexed offsets.
`timescale 1ns/1ps
`default_nettype none
module bcx_exec #(
  parameter int ADDR_W = 12,
  parameter int POST_W = 7,
  parameter int WDT_W = 8
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [15:0] INSTR_WORD,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  input wire logic EXT_SET_EN,
  input wire logic [ADDR_W-1:0] INDEX_BASE,
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_DATA,
  input wire logic FLAGS_LOAD,
  input wire logic [4:0] FLAGS_DATA,
  input wire logic BANK_LOAD,
  input wire logic [ADDR_W-9:0] BANK_DATA,
  input wire logic FILE_WE,
  input wire logic [ADDR_W-1:0] FILE_ADDR,
  input wire logic [7:0] FILE_DATA,
  input wire logic SLEEP_CMD,
  output logic [20:0] PC_OUT,
  output logic PC_LOAD,
  output logic [20:0] STACK_TOP,
  output logic STACK_PUSH,
  output logic [7:0] ACCUMULATOR,
  output logic [4:0] STATUS_FLAGS,
  output logic [ADDR_W-9:0] BANK_SELECT_REG,
  output logic [7:0] ACCUMULATOR_SHADOW,
  output logic [4:0] FLAGS_SHADOW,
  output logic [ADDR_W-9:0] BANK_SELECT_SHADOW,
  output logic [WDT_W-1:0] WDT_COUNT,
  output logic WATCHDOG_EXPIRY_FLAG_N,
  output logic SLEEP_ENTRY_FLAG_N
);
  if (ADDR_W != 12 || POST_W < 1 || WDT_W < 1) begin : g_check
    $error("bcx_exec: address width must be 12 and counters at least one bit");
  end

  bcx_pkg::bcx_state_t state_reg;
  bcx_pkg::bcx_state_t state_next;
  logic [20:0] pc_reg, call_pc_reg, stack_reg;
  logic [7:0] acc_reg, acc_sh_reg, call_lo_reg;
  logic [4:0] flags_reg, flags_sh_reg;
  logic [ADDR_W-9:0] bank_reg, bank_sh_reg;
  logic [POST_W-1:0] post_reg;
  logic [WDT_W-1:0] wdt_reg;
  logic to_n_reg, pd_n_reg, save_reg, skip_reg, pc_load_reg, push_reg;
  logic [1:0] kind_reg;
  logic ext_meta_reg, ext_reg;
  logic [7:0] rdata;

  // decode of the presented word
  wire take = CE && INSTR_VALID && INSTR_READY;
  wire cmp_hit = (kind_reg == bcx_pkg::CMP_LESS && rdata < acc_reg)
    || (kind_reg == bcx_pkg::CMP_EQUAL && rdata == acc_reg)
    || (kind_reg == bcx_pkg::CMP_GREATER && rdata > acc_reg);
  wire dec_state = state_reg == bcx_pkg::S_DECODE || state_reg == bcx_pkg::S_CMP;
  wire skip_cur = state_reg == bcx_pkg::S_CMP ? cmp_hit : skip_reg;
  wire skip_now = take && dec_state && skip_cur;
  wire exec = take && dec_state && !skip_cur;
  wire is_bz = INSTR_WORD[15:8] == bcx_pkg::OP_BRANCH_ZERO;
  wire is_call = INSTR_WORD[15:9] == bcx_pkg::OP_CALL;
  wire is_clear_file_register = INSTR_WORD[15:9] == bcx_pkg::OP_CLEAR_FILE;
  wire is_cwdt = INSTR_WORD == bcx_pkg::OP_WATCHDOG_RESTART;
  wire is_cmp = INSTR_WORD[15:11] == bcx_pkg::OP_COMPARE && INSTR_WORD[10:9] != 2'h3;
  wire is_two_word = INSTR_WORD[15:12] == bcx_pkg::OP_MOVE_FF || is_call
    || INSTR_WORD[15:8] == bcx_pkg::OP_GOTO || INSTR_WORD[15:8] == bcx_pkg::OP_LOAD_INDEX;
  wire zero_flag = flags_reg[bcx_pkg::ZERO_BIT];
  wire [20:0] bz_target = pc_reg + bcx_pkg::PC_STEP
    + {{12{INSTR_WORD[7]}}, INSTR_WORD[7:0], 1'b0};
  wire [20:0] pc_inc = pc_reg + bcx_pkg::PC_STEP;

  // file address: indexed offset, access bank or banked
  wire [7:0] fld = INSTR_WORD[7:0];
  wire low_file = fld <= bcx_pkg::INDEX_LIMIT;
  wire indexed = !INSTR_WORD[8] && ext_reg && low_file;
  wire [ADDR_W-1:0] idx_addr = INDEX_BASE + {{(ADDR_W-8){1'b0}}, fld};
  wire [ADDR_W-1:0] acc_bank_addr = low_file ? {bcx_pkg::LOW_ACCESS_BANK, fld}
    : {bcx_pkg::HIGH_ACCESS_BANK, fld};
  wire [ADDR_W-1:0] eff_addr = indexed ? idx_addr
    : (INSTR_WORD[8] ? {bank_reg, fld} : acc_bank_addr);

  wire clr_we = exec && is_clear_file_register;
  wire mem_we = clr_we || FILE_WE;
  wire [ADDR_W-1:0] mem_waddr = clr_we ? eff_addr : FILE_ADDR;
  wire [7:0] mem_wdata = clr_we ? 8'h00 : FILE_DATA;

  wire call_done = take && state_reg == bcx_pkg::S_CALL2;
  wire post_wrap = &post_reg;
  wire wdt_expire = post_wrap && &wdt_reg;

  bcx_file_ram #(.ADDR_W(ADDR_W), .DATA_W(8)) u_ram (
    .clk(CLOCK),
    .ce(CE),
    .we(mem_we),
    .waddr(mem_waddr),
    .raddr(eff_addr),
    .wdata(mem_wdata),
    .rdata(rdata)
  );

  assign INSTR_READY = state_reg == bcx_pkg::S_DECODE || state_reg == bcx_pkg::S_CALL2
    || state_reg == bcx_pkg::S_SKIP2 || state_reg == bcx_pkg::S_CMP;
  assign PC_OUT = pc_reg;
  assign PC_LOAD = pc_load_reg;
  assign STACK_TOP = stack_reg;
  assign STACK_PUSH = push_reg;
  assign ACCUMULATOR = acc_reg;
  assign STATUS_FLAGS = flags_reg;
  assign BANK_SELECT_REG = bank_reg;
  assign ACCUMULATOR_SHADOW = acc_sh_reg;
  assign FLAGS_SHADOW = flags_sh_reg;
  assign BANK_SELECT_SHADOW = bank_sh_reg;
  assign WDT_COUNT = wdt_reg;
  assign WATCHDOG_EXPIRY_FLAG_N = to_n_reg;
  assign SLEEP_ENTRY_FLAG_N = pd_n_reg;

  always_comb begin
    state_next = state_reg == bcx_pkg::S_CMP ? bcx_pkg::S_DECODE : state_reg;
    case (state_reg)
      bcx_pkg::S_DECODE, bcx_pkg::S_CMP: begin
        if (skip_now) begin
          state_next = is_two_word ? bcx_pkg::S_SKIP2 : bcx_pkg::S_DECODE;
        end else if (exec && is_bz && zero_flag) begin
          state_next = bcx_pkg::S_DEAD;
        end else if (exec && is_call) begin
          state_next = bcx_pkg::S_CALL2;
        end else if (exec && is_cmp) begin
          state_next = bcx_pkg::S_CMP;
        end
      end
      bcx_pkg::S_CALL2: if (take) state_next = bcx_pkg::S_DECODE;
      bcx_pkg::S_SKIP2: if (take) state_next = bcx_pkg::S_DECODE;
      bcx_pkg::S_DEAD: if (CE) state_next = bcx_pkg::S_DECODE;
      default: state_next = bcx_pkg::S_DECODE;
    endcase
  end

  // configuration pin comes from outside the clock domain
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ext_meta_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else if (CE) begin
      ext_meta_reg <= EXT_SET_EN;
      ext_reg <= ext_meta_reg;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_reg <= bcx_pkg::S_DECODE;
      pc_reg <= bcx_pkg::PC_RESET;
      pc_load_reg <= 1'b0;
      push_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      pc_load_reg <= (exec && is_bz && zero_flag) || call_done;
      push_reg <= call_done;
      if (exec && is_bz && zero_flag) begin
        pc_reg <= bz_target;
      end else if (call_done) begin
        pc_reg <= {INSTR_WORD[11:0], call_lo_reg, 1'b0};
      end else if (take) begin
        pc_reg <= pc_inc;
      end
      if (state_reg == bcx_pkg::S_CMP && !take) begin
        skip_reg <= cmp_hit;
      end else if (take && dec_state) begin
        skip_reg <= 1'b0;
      end
    end
  end

  // call bookkeeping and compare kind
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      call_pc_reg <= bcx_pkg::PC_RESET;
      call_lo_reg <= 8'h00;
      save_reg <= 1'b0;
      kind_reg <= bcx_pkg::CMP_LESS;
      stack_reg <= bcx_pkg::PC_RESET;
    end else if (CE) begin
      if (exec && is_call) begin
        call_pc_reg <= pc_reg;
        call_lo_reg <= INSTR_WORD[7:0];
        save_reg <= INSTR_WORD[8];
      end
      if (exec && is_cmp) begin
        kind_reg <= INSTR_WORD[10:9];
      end
      if (call_done) begin
        stack_reg <= call_pc_reg + bcx_pkg::CALL_RETURN_STEP;
      end
    end
  end

  // working registers and their shadows
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      acc_reg <= 8'h00;
      flags_reg <= bcx_pkg::FLAGS_RESET;
      bank_reg <= '0;
      acc_sh_reg <= 8'h00;
      flags_sh_reg <= bcx_pkg::FLAGS_RESET;
      bank_sh_reg <= '0;
    end else if (CE) begin
      if (ACC_LOAD) acc_reg <= ACC_DATA;
      if (BANK_LOAD) bank_reg <= BANK_DATA;
      if (FLAGS_LOAD) flags_reg <= FLAGS_DATA;
      if (clr_we) flags_reg[bcx_pkg::ZERO_BIT] <= 1'b1;
      if (call_done && save_reg) begin
        acc_sh_reg <= acc_reg;
        flags_sh_reg <= flags_reg;
        bank_sh_reg <= bank_reg;
      end
    end
  end

  // watchdog count with postscaler; restart wins over expiry
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      post_reg <= '0;
      wdt_reg <= '0;
      to_n_reg <= 1'b1;
      pd_n_reg <= 1'b1;
    end else if (CE) begin
      if (exec && is_cwdt) begin
        post_reg <= '0;
        wdt_reg <= '0;
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b1;
      end else begin
        post_reg <= post_reg + 1'b1;
        if (post_wrap) wdt_reg <= wdt_reg + 1'b1;
        if (wdt_expire) to_n_reg <= 1'b0;
        if (SLEEP_CMD) pd_n_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_bz_taken: assert property (CE && exec && is_bz && zero_flag |=>
    pc_reg == $past(bz_target) && !INSTR_READY && PC_LOAD)
    else $error("taken zero branch wrong target or no dead cycle");
  a_bz_untaken: assert property (CE && exec && is_bz && !zero_flag |=>
    pc_reg == $past(pc_inc) && INSTR_READY)
    else $error("untaken zero branch must step by two");
  a_call_push: assert property (call_done |=>
    stack_reg == $past(call_pc_reg) + bcx_pkg::CALL_RETURN_STEP
    && pc_reg == {$past(INSTR_WORD[11:0]), $past(call_lo_reg), 1'b0} && STACK_PUSH)
    else $error("call did not push return or load target");
  a_shadow_save: assert property (call_done && save_reg |=>
    acc_sh_reg == $past(acc_reg) && flags_sh_reg == $past(flags_reg) && bank_sh_reg == $past(bank_reg))
    else $error("shadow copy missing on saving call");
  a_shadow_keep: assert property (!(call_done && save_reg) |=> $stable(acc_sh_reg)
    && $stable(flags_sh_reg) && $stable(bank_sh_reg))
    else $error("shadow changed without saving call");
  a_clear_file: assert property (CE && exec && is_clear_file_register |->
    mem_we && mem_wdata == 8'h00 && mem_waddr == eff_addr ##1 flags_reg[bcx_pkg::ZERO_BIT] && INSTR_READY)
    else $error("clear file did not zero the file or set zero flag");
  a_wdt_restart: assert property (CE && exec && is_cwdt |=>
    wdt_reg == '0 && post_reg == '0 && to_n_reg && pd_n_reg)
    else $error("watchdog restart incomplete");
  a_cmp_less: assert property (CE && state_reg == bcx_pkg::S_CMP && kind_reg == bcx_pkg::CMP_LESS
    && !take |=> skip_reg == ($past(rdata) < $past(acc_reg)))
    else $error("less compare skip decision wrong");
  a_skip_two: assert property (skip_now && is_two_word
    |=> state_reg == bcx_pkg::S_SKIP2 && !PC_LOAD)
    else $error("skipped two-word instruction not fully discarded");
  a_index_addr: assert property (!INSTR_WORD[8] && ext_reg && fld <= bcx_pkg::INDEX_LIMIT
    |-> eff_addr == INDEX_BASE + {{(ADDR_W-8){1'b0}}, fld})
    else $error("indexed literal offset address wrong");
  a_cmp_equal: assert property (CE && state_reg == bcx_pkg::S_CMP && kind_reg == bcx_pkg::CMP_EQUAL
    && !take |=> skip_reg == ($past(rdata) == $past(acc_reg)))
    else $error("equal compare skip decision wrong");
  a_cmp_discard: assert property (skip_now && !is_two_word |=>
    pc_reg == $past(pc_inc) && !PC_LOAD && !STACK_PUSH && state_reg == bcx_pkg::S_DECODE)
    else $error("skipped instruction was not discarded");
endmodule
`default_nettype wire

/* tb/bcx_fetch_model.sv */
// fetch unit model: hands queued instruction words over a valid/ready handshake
`timescale 1ns/1ps
`default_nettype none
module bcx_fetch_model (
  input wire logic clk,
  input wire logic ce,
  input wire logic ready,
  input wire logic slow,
  output logic valid,
  output logic [15:0] word
);
  logic [15:0] fifo[$];
  logic rest;
  initial begin
    valid = 1'b0;
    word = 16'h5A5A;
    rest = 1'b0;
  end
  // a word holds until the edge that takes it; when idle the word lines keep changing
  always @(posedge clk) begin
    if (valid && ready && ce) begin
      void'(fifo.pop_front());
      rest = slow;
    end else begin
      rest = 1'b0;
    end
    @(negedge clk);
    if (fifo.size() != 0 && !rest) begin
      valid = 1'b1;
      word = fifo[0];
    end else begin
      valid = 1'b0;
      word = ~word;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the branch, call, clear and compare executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLOCK = 1'b0, RESETN = 1'b0, EXT_SET_EN = 1'b0, ACC_LOAD = 1'b0, FLAGS_LOAD = 1'b0, BANK_LOAD = 1'b0;
  logic FILE_WE = 1'b0, SLEEP_CMD = 1'b0, slow = 1'b0, INSTR_VALID, INSTR_READY, PC_LOAD, STACK_PUSH, WDOG_N, SLP_N;
  logic CE = 1'b1;
  logic [15:0] INSTR_WORD;
  logic [11:0] INDEX_BASE = 12'h000, FILE_ADDR = 12'h000;
  logic [7:0] ACC_DATA = 8'h00, FILE_DATA = 8'h00, ACCUMULATOR, ACC_SH, WDT_COUNT;
  logic [4:0] FLAGS_DATA = 5'h00, STATUS_FLAGS, FLAGS_SH;
  logic [3:0] BANK_DATA = 4'h0, BANK_SELECT_REG, BANK_SH;
  logic [20:0] PC_OUT, STACK_TOP, pc;
  int err_count = 0, num_checks = 0, loads = 0, pushes = 0, refused = 0;
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    loads += int'(PC_LOAD === 1'b1);
    pushes += int'(STACK_PUSH === 1'b1);
    refused += int'(INSTR_VALID === 1'b1 && INSTR_READY === 1'b0);
  end
  bcx_exec i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
    .INSTR_READY(INSTR_READY), .EXT_SET_EN(EXT_SET_EN), .INDEX_BASE(INDEX_BASE), .ACC_LOAD(ACC_LOAD),
    .ACC_DATA(ACC_DATA), .FLAGS_LOAD(FLAGS_LOAD), .FLAGS_DATA(FLAGS_DATA), .BANK_LOAD(BANK_LOAD),
    .BANK_DATA(BANK_DATA), .FILE_WE(FILE_WE), .FILE_ADDR(FILE_ADDR), .FILE_DATA(FILE_DATA),
    .SLEEP_CMD(SLEEP_CMD), .PC_OUT(PC_OUT), .PC_LOAD(PC_LOAD), .STACK_TOP(STACK_TOP), .STACK_PUSH(STACK_PUSH),
    .ACCUMULATOR(ACCUMULATOR), .STATUS_FLAGS(STATUS_FLAGS), .BANK_SELECT_REG(BANK_SELECT_REG),
    .ACCUMULATOR_SHADOW(ACC_SH), .FLAGS_SHADOW(FLAGS_SH), .BANK_SELECT_SHADOW(BANK_SH),
    .WDT_COUNT(WDT_COUNT), .WATCHDOG_EXPIRY_FLAG_N(WDOG_N), .SLEEP_ENTRY_FLAG_N(SLP_N));
  bcx_fetch_model i_fetch (.clk(CLOCK), .ce(CE), .ready(INSTR_READY), .slow(slow), .valid(INSTR_VALID),
    .word(INSTR_WORD));
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic setregs(input logic [7:0] a, input logic [4:0] f, input logic [3:0] b);
    @(negedge CLOCK);
    {ACC_LOAD, FLAGS_LOAD, BANK_LOAD, ACC_DATA, FLAGS_DATA, BANK_DATA} = {3'h7, a, f, b};
    @(negedge CLOCK);
    {ACC_LOAD, FLAGS_LOAD, BANK_LOAD} = 3'h0;
  endtask
  task automatic wfile(input logic [11:0] ad, input logic [7:0] d);
    @(negedge CLOCK);
    {FILE_WE, FILE_ADDR, FILE_DATA} = {1'b1, ad, d};
    @(negedge CLOCK);
    FILE_WE = 1'b0;
  endtask
  // queue words, wait boundedly until all are taken and the executor is ready again
  task automatic run(input logic [15:0] w[$]);
    int n;
    foreach (w[i]) i_fetch.fifo.push_back(w[i]);
    for (n = 0; n < 60 && !(i_fetch.fifo.size() == 0 && INSTR_READY === 1'b1); n++) @(negedge CLOCK);
    if (n == 60) begin
      err_count++;
      $display("unexpected at %0t: fetch stalled", $time);
      print_verdict();
    end else repeat (2) @(negedge CLOCK);
  endtask
  task automatic t_wdt();
    repeat (300) @(negedge CLOCK);
    SLEEP_CMD = 1'b1;
    @(negedge CLOCK);
    SLEEP_CMD = 1'b0;
    @(negedge CLOCK);
    check(21'(SLP_N), 21'h0);
    run('{16'h0004});
    pc = pc + 21'h2;
    check(21'({WDT_COUNT, WDOG_N, SLP_N}), 21'h3);
    check(PC_OUT, pc);
    $display("watchdog restart test done");
  endtask
  task automatic t_branch();
    int l0;
    slow = 1'b1;
    setregs(8'h00, 5'h04, 4'h0);
    l0 = loads;
    run('{16'hE003, 16'hE0FE});
    check(PC_OUT, pc + 21'h6);
    setregs(8'h00, 5'h00, 4'h0);
    run('{16'hE005});
    pc = pc + 21'h8;
    check(PC_OUT, pc);
    check(21'(loads - l0), 21'h2);
    slow = 1'b0;
    $display("branch test done");
  endtask
  task automatic t_call();
    int p0;
    p0 = pushes;
    setregs(8'h5A, 5'h13, 4'hA);
    run('{16'hED34, 16'hF012});
    check(STACK_TOP, pc + 21'h4);
    check(PC_OUT, 21'h002468);
    check(21'({ACC_SH, FLAGS_SH, BANK_SH}), 21'({8'h5A, 5'h13, 4'hA}));
    setregs(8'h33, 5'h08, 4'h3);
    run('{16'hEC00, 16'hF000});
    pc = 21'h0;
    check(STACK_TOP, 21'h00246C);
    check(21'({ACCUMULATOR, STATUS_FLAGS, BANK_SELECT_REG}), 21'({8'h33, 5'h08, 4'h3}));
    check(PC_OUT, pc);
    check(21'({ACC_SH, FLAGS_SH, BANK_SH}), 21'({8'h5A, 5'h13, 4'hA}));
    check(21'(pushes - p0), 21'h2);
    $display("call test done");
  endtask
  task automatic t_clear();
    int l0;
    wfile(12'h240, 8'h77);
    setregs(8'h00, 5'h1B, 4'h2);
    run('{16'h6B40});
    check(21'(STATUS_FLAGS), 21'h1F);
    l0 = loads;
    run('{16'h6340, 16'hE005});
    pc = pc + 21'h6;
    check(PC_OUT, pc);
    check(21'(loads - l0), 21'h0);
    $display("clear file test done");
  endtask
  // a skipped victim branch leaves the count linear; an executed one jumps ahead
  task automatic t_cmp(input logic [7:0] op, input logic [11:0] wa, input logic [7:0] f, fv, av, input logic skip);
    wfile(wa, fv);
    setregs(av, 5'h04, 4'h2);
    run('{{op, f}, 16'hE005});
    pc = skip ? pc + 21'h4 : pc + 21'hE;
    check(PC_OUT, pc);
  endtask
  task automatic t_compares();
    int p0, r0;
    slow = 1'b1;
    t_cmp(8'h61, 12'h250, 8'h50, 8'h10, 8'h20, 1'b1);
    t_cmp(8'h61, 12'h250, 8'h50, 8'h20, 8'h10, 1'b0);
    t_cmp(8'h61, 12'h250, 8'h50, 8'h10, 8'h90, 1'b1);
    t_cmp(8'h61, 12'h250, 8'h50, 8'h44, 8'h44, 1'b0);
    t_cmp(8'h63, 12'h250, 8'h50, 8'h33, 8'h33, 1'b1);
    t_cmp(8'h63, 12'h250, 8'h50, 8'h33, 8'h34, 1'b0);
    slow = 1'b0;
    t_cmp(8'h65, 12'h250, 8'h50, 8'h90, 8'h10, 1'b1);
    t_cmp(8'h65, 12'h250, 8'h50, 8'h10, 8'h90, 1'b0);
    t_cmp(8'h65, 12'h250, 8'h50, 8'h44, 8'h44, 1'b0);
    p0 = pushes;
    wfile(12'h250, 8'h90);
    setregs(8'h10, 5'h04, 4'h2);
    r0 = refused;
    // only the taken branch may refuse a word: the compare and its two-word victim cost three cycles
    run('{16'h6550, 16'hEC01, 16'hF000, 16'hE005, 16'h0000});
    pc = pc + 21'h14;
    check(PC_OUT, pc);
    check(21'(pushes - p0), 21'h0);
    check(21'(refused - r0), 21'h1);
    $display("compare skip test done");
  endtask
  task automatic t_index();
    EXT_SET_EN = 1'b1;
    INDEX_BASE = 12'h300;
    repeat (3) @(negedge CLOCK);
    wfile(12'h05F, 8'h00);
    t_cmp(8'h62, 12'h35F, 8'h5F, 8'h42, 8'h42, 1'b1);
    wfile(12'h360, 8'h00);
    t_cmp(8'h62, 12'hF60, 8'h60, 8'h42, 8'h42, 1'b1);
    EXT_SET_EN = 1'b0;
    repeat (3) @(negedge CLOCK);
    wfile(12'h35F, 8'h11);
    t_cmp(8'h62, 12'h05F, 8'h5F, 8'h42, 8'h42, 1'b1);
    $display("indexed offset test done");
  endtask
  // a low clock enable must hold the status flags and the PC and leave a queued word untaken
  task automatic t_freeze();
    @(negedge CLOCK);
    CE = 1'b0;
    {FLAGS_LOAD, FLAGS_DATA} = {1'b1, 5'h1F};
    i_fetch.fifo.push_back(16'h0004);
    repeat (4) @(negedge CLOCK);
    check(21'(STATUS_FLAGS), 21'h04);
    check(PC_OUT, pc);
    check(21'(i_fetch.fifo.size()), 21'h1);
    {CE, FLAGS_LOAD} = 2'h2;
    run('{16'h0000});
    pc = pc + 21'h4;
    check(PC_OUT, pc);
    check(21'({WDT_COUNT, WDOG_N, SLP_N}), 21'h3);
    $display("clock enable freeze test done");
  endtask
  initial begin
    pc = 21'h0;
    repeat (3) @(negedge CLOCK);
    RESETN = 1'b1;
    t_wdt();
    t_branch();
    t_call();
    t_clear();
    t_compares();
    t_index();
    t_freeze();
    print_verdict();
  end
endmodule
`default_nettype wire
